// [odls_top.sv]
`include "odls_params.svh"
`default_nettype none
module odls_top #(
   parameter int unsigned TICK_CYC = `ODLS_CLK_HZ / 1000 * `ODLS_TICK_MS
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [5:0] test_select_jumpers_i,
   input wire logic [15:0] wakeup_jumpers_i,
   input wire logic [4:0] drive_present_i,
   output logic op_valid_o,
   output odls_pkg::odls_op_t op_code_o,
   output logic [2:0] op_unit_o,
   output logic [15:0] op_arg_o,
   input wire logic op_done_i,
   input wire logic op_err_i,
   input wire logic [7:0] op_err_code_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [23:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [7:0] mem_rdata_i,
   output logic error_lamp_o,
   output logic ready_lamp_o
);
   import odls_pkg::*;
   typedef enum logic [3:0] {S_BOOT, S_SEL, S_ISSUE, S_WAIT, S_NEXT, S_RDYWAIT, S_MEM, S_PAD,
      S_PASS, S_ADDR, S_FAIL, S_HALT} odls_state_t;

   odls_lamp_if lif ();
   odls_state_t state_reg;
   logic [5:0] jmp_s1, jmp_s2;
   logic [15:0] wua_s1, wua_s2;
   logic [4:0] prs_s1, prs_s2;
   logic [1:0] boot_reg;
   logic [23:0] div_reg;
   logic tick_reg;
   odls_lmode_t mode_reg;
   logic [15:0] word_reg;
   logic [4:0] test_reg;
   logic sys_reg;
   logic [2:0] idx_reg;
   logic [3:0] step_reg;
   logic [7:0] it_reg;
   logic [11:0] madr_reg;
   logic mrd_reg;
   logic [4:0] pt_reg;
   logic pass_tgl_reg;
   odls_step_t cur_step;

   function automatic logic [4:0] sys_code(input logic [2:0] i);
      unique case (i)
         3'h0: sys_code = `ODLS_T_ENV;
         3'h1: sys_code = `ODLS_T_RWC;
         3'h2: sys_code = `ODLS_T_FLP0;
         3'h3: sys_code = `ODLS_T_FLP1;
         3'h4: sys_code = `ODLS_T_WIN0;
         3'h5: sys_code = `ODLS_T_WIN1;
         default: sys_code = `ODLS_T_TAPE;
      endcase
   endfunction : sys_code

   function automatic logic [2:0] unit_of(input logic [4:0] c);
      return 3'(`ODLS_T_FLP0 - c);
   endfunction : unit_of

   function automatic logic present(input logic [4:0] c, input logic [4:0] p);
      if (c == `ODLS_T_ENV || c == `ODLS_T_RWC)
         return 1'b1;
      return p[unit_of(c)];
   endfunction : present

   function automatic odls_step_t step_of(input logic [4:0] c, input logic [3:0] s);
      odls_step_t r;
      r = '{OP_ENV_TEST, 16'h0000, `ODLS_REP1, 1'b1};
      if (c == `ODLS_T_RWC)
         r.op = OP_SEQ_TEST;
      else if (c == `ODLS_T_FLP0 || c == `ODLS_T_FLP1 || c == `ODLS_T_WIN0 || c == `ODLS_T_WIN1)
      begin
         r.last = 1'b0;
         unique case (s)
            4'h0: r.op = OP_SEEK_HOME;
            4'h1:
            begin
               r.op = OP_STEP_OUT;
               r.arg = (c == `ODLS_T_WIN0 || c == `ODLS_T_WIN1) ? `ODLS_WIN_TRACKS
                  : `ODLS_FLP_TRACKS;
            end
            4'h2: r.op = OP_SEEK_ZERO;
            4'h3: r.op = OP_READ_ID;
            4'h4:
               if (c == `ODLS_T_WIN0 || c == `ODLS_T_WIN1)
                  r = '{OP_READ_ECC, 16'h0000, `ODLS_WIN_READS, 1'b1};
               else
                  r = '{OP_WRITE_SECT, 16'h0000, `ODLS_FLP_SECTS, 1'b0};
            default: r = '{OP_VERIFY_SECT, 16'h0000, `ODLS_FLP_SECTS, 1'b1};
         endcase
      end
      else if (c == `ODLS_T_TAPE)
      begin
         unique case (s)
            4'h0: r = '{OP_RETENSION, 16'h0000, `ODLS_REP1, 1'b0};
            4'h1: r = '{OP_TAPE_WRITE, 16'h0000, `ODLS_TAPE_TRACKS, 1'b0};
            default: r = '{OP_TAPE_VERIFY, 16'h0000, `ODLS_TAPE_TRACKS, 1'b1};
         endcase
      end
      return r;
   endfunction : step_of

   assign cur_step = step_of(test_reg, step_reg);
   assign lif.tick = tick_reg;
   assign lif.mode = mode_reg;
   assign lif.word = word_reg;

   odls_lamp_seq u_lamp (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .lif(lif)
   );

   // Jumpers and presence lines come from pins
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         jmp_s1 <= 6'h00;
         jmp_s2 <= 6'h00;
         wua_s1 <= 16'h0000;
         wua_s2 <= 16'h0000;
         prs_s1 <= 5'h00;
         prs_s2 <= 5'h00;
         boot_reg <= 2'h0;
      end
      else
      begin
         jmp_s1 <= test_select_jumpers_i;
         jmp_s2 <= jmp_s1;
         wua_s1 <= wakeup_jumpers_i;
         wua_s2 <= wua_s1;
         prs_s1 <= drive_present_i;
         prs_s2 <= prs_s1;
         boot_reg <= {boot_reg[0], 1'b1};
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_reg <= 24'h000000;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= (div_reg == 24'(TICK_CYC - 1));
         div_reg <= (div_reg == 24'(TICK_CYC - 1)) ? 24'h000000 : div_reg + 24'h000001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         error_lamp_o <= 1'b0;
         ready_lamp_o <= 1'b0;
      end
      else
      begin
         error_lamp_o <= lif.err_lamp;
         ready_lamp_o <= (mode_reg == LM_OFF) ? pass_tgl_reg : lif.rdy_lamp;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= S_BOOT;
         mode_reg <= LM_OFF;
         word_reg <= 16'h0000;
         test_reg <= `ODLS_T_ENV;
         sys_reg <= 1'b0;
         idx_reg <= 3'h0;
         step_reg <= 4'h0;
         it_reg <= 8'h00;
         madr_reg <= 12'h000;
         mrd_reg <= 1'b0;
         pt_reg <= 5'h00;
         pass_tgl_reg <= 1'b0;
         op_valid_o <= 1'b0;
         op_code_o <= OP_ENV_TEST;
         op_unit_o <= 3'h0;
         op_arg_o <= 16'h0000;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= 24'h000000;
         mem_wdata_o <= 8'h00;
      end
      else
      begin
         if (tick_reg && pt_reg != 5'h1F)
            pt_reg <= pt_reg + 5'h01;
         unique case (state_reg)
            S_BOOT:
               if (boot_reg[1])
                  state_reg <= S_SEL;
            S_SEL:
            begin
               test_reg <= jmp_s2[4:0];
               step_reg <= 4'h0;
               it_reg <= 8'h00;
               pt_reg <= 5'h00;
               if (jmp_s2[`ODLS_EN_BIT])
                  state_reg <= S_HALT;
               else if (jmp_s2[4:0] == `ODLS_T_ADDR)
               begin
                  state_reg <= S_ADDR;
                  mode_reg <= LM_ADDR;
                  word_reg <= wua_s2;
               end
               else if (jmp_s2[4:0] == `ODLS_T_MEM)
                  state_reg <= S_RDYWAIT;
               else if (jmp_s2[4:0] == `ODLS_T_SYS)
               begin
                  sys_reg <= 1'b1;
                  idx_reg <= 3'h0;
                  test_reg <= `ODLS_T_ENV;
                  if (prs_s2 == 5'h00)
                  begin
                     state_reg <= S_FAIL;
                     mode_reg <= LM_ERR;
                     word_reg <= {8'h00, `ODLS_ERR_NODRV};
                  end
                  else
                     state_reg <= S_ISSUE;
               end
               else if (jmp_s2[4:0] < `ODLS_T_TAPE || jmp_s2[4:0] == 5'h1C
                  || jmp_s2[4:0] == 5'h1D || jmp_s2[4:0] == 5'h1E)
                  state_reg <= S_HALT;
               else if (present(jmp_s2[4:0], prs_s2))
                  state_reg <= S_ISSUE;
               else
               begin
                  state_reg <= S_FAIL;
                  mode_reg <= LM_ERR;
                  word_reg <= {8'h00, `ODLS_ERR_NODRV};
               end
            end
            S_ISSUE:
            begin
               op_valid_o <= 1'b1;
               op_code_o <= cur_step.op;
               op_unit_o <= unit_of(test_reg);
               op_arg_o <= cur_step.arg + {8'h00, it_reg};
               state_reg <= S_WAIT;
            end
            S_WAIT:
               if (op_done_i)
               begin
                  op_valid_o <= 1'b0;
                  if (op_err_i)
                  begin
                     state_reg <= S_FAIL;
                     mode_reg <= LM_ERR;
                     word_reg <= {8'h00, op_err_code_i};
                  end
                  else if (it_reg + 8'h01 < cur_step.reps)
                  begin
                     it_reg <= it_reg + 8'h01;
                     state_reg <= S_ISSUE;
                  end
                  else
                  begin
                     it_reg <= 8'h00;
                     step_reg <= step_reg + 4'h1;
                     if (!cur_step.last)
                        state_reg <= S_ISSUE;
                     else
                        state_reg <= sys_reg ? S_NEXT : S_PASS;
                  end
               end
            S_NEXT:
            begin
               step_reg <= 4'h0;
               if (idx_reg == `ODLS_SYS_LAST)
                  state_reg <= S_PASS;
               else
               begin
                  idx_reg <= idx_reg + 3'h1;
                  test_reg <= sys_code(idx_reg + 3'h1);
                  if (present(sys_code(idx_reg + 3'h1), prs_s2))
                     state_reg <= S_ISSUE;
               end
            end
            S_RDYWAIT:
               if (pt_reg >= 5'(`ODLS_READY_TICKS))
               begin
                  pt_reg <= 5'h00;
                  state_reg <= S_MEM;
               end
            S_MEM:
               if (!mem_req_o)
               begin
                  mem_req_o <= 1'b1;
                  mem_we_o <= !mrd_reg;
                  mem_addr_o <= {12'h000, madr_reg};
                  mem_wdata_o <= madr_reg[7:0];
               end
               else if (mem_ack_i)
               begin
                  mem_req_o <= 1'b0;
                  madr_reg <= madr_reg + 12'h001;
                  if (mrd_reg && mem_rdata_i != madr_reg[7:0])
                  begin
                     state_reg <= S_FAIL;
                     mode_reg <= LM_ERR;
                     word_reg <= {8'h00, `ODLS_ERR_MEM};
                  end
                  else if (madr_reg == `ODLS_MEM_LAST)
                  begin
                     mrd_reg <= !mrd_reg;
                     if (mrd_reg)
                        state_reg <= S_PAD;
                  end
               end
            S_PAD:
               if (pt_reg >= 5'(`ODLS_RUN_TICKS))
                  state_reg <= S_PASS;
            S_PASS:
            begin
               pass_tgl_reg <= !pass_tgl_reg;
               step_reg <= 4'h0;
               it_reg <= 8'h00;
               pt_reg <= 5'h00;
               idx_reg <= 3'h0;
               if (sys_reg)
                  test_reg <= `ODLS_T_ENV;
               state_reg <= (test_reg == `ODLS_T_MEM) ? S_MEM : S_ISSUE;
            end
            S_ADDR:
               word_reg <= wua_s2;
            S_FAIL:
               mode_reg <= LM_ERR;
            S_HALT:
               mode_reg <= LM_OFF;
         endcase
      end
   end
endmodule : odls_top
`default_nettype wire

// [odls_params.svh]
`ifndef ODLS_PARAMS_SVH
`define ODLS_PARAMS_SVH
`define ODLS_CLK_HZ 25000000
`define ODLS_TICK_MS 250
`define ODLS_LEAD_MS 3000
`define ODLS_PAUSE_MS 2000
`define ODLS_MEM_READY_MS 3000
`define ODLS_MEM_RUN_MS 2000
`define ODLS_LEAD_TICKS (`ODLS_LEAD_MS / `ODLS_TICK_MS)
`define ODLS_PAUSE_TICKS (`ODLS_PAUSE_MS / `ODLS_TICK_MS)
`define ODLS_READY_TICKS (`ODLS_MEM_READY_MS / `ODLS_TICK_MS)
`define ODLS_RUN_TICKS (`ODLS_MEM_RUN_MS / `ODLS_TICK_MS)
`define ODLS_PULSE_TICKS 1
`define ODLS_ADDR_BITS 4'h8
`define ODLS_EN_BIT 5
`define ODLS_T_ENV 5'h1F
`define ODLS_T_RWC 5'h1B
`define ODLS_T_ADDR 5'h1A
`define ODLS_T_FLP0 5'h19
`define ODLS_T_FLP1 5'h18
`define ODLS_T_WIN0 5'h17
`define ODLS_T_WIN1 5'h16
`define ODLS_T_TAPE 5'h15
`define ODLS_T_SYS 5'h14
`define ODLS_T_MEM 5'h13
`define ODLS_SYS_LAST 3'h6
`define ODLS_ERR_NODRV 8'h47
`define ODLS_ERR_MEM 8'hE1
`define ODLS_MEM_LAST 12'hFFF
`define ODLS_FLP_TRACKS 16'h0023
`define ODLS_WIN_TRACKS 16'h0080
`define ODLS_FLP_SECTS 8'h10
`define ODLS_WIN_READS 8'h0C
`define ODLS_TAPE_TRACKS 8'h02
`define ODLS_REP1 8'h01
`endif

// [odls_pkg.sv]
`default_nettype none
package odls_pkg;
   typedef enum logic [3:0] {OP_ENV_TEST, OP_SEQ_TEST, OP_SEEK_HOME, OP_STEP_OUT, OP_SEEK_ZERO,
      OP_READ_ID, OP_WRITE_SECT, OP_VERIFY_SECT, OP_READ_ECC, OP_RETENSION, OP_TAPE_WRITE,
      OP_TAPE_VERIFY} odls_op_t;
   typedef enum logic [1:0] {LM_OFF, LM_ADDR, LM_ERR} odls_lmode_t;
   typedef struct packed {
      odls_op_t op;
      logic [15:0] arg;
      logic [7:0] reps;
      logic last;
   } odls_step_t;
endpackage : odls_pkg
`default_nettype wire

// [odls_lamp_if.sv]
`default_nettype none
interface odls_lamp_if;
   logic tick;
   odls_pkg::odls_lmode_t mode;
   logic [15:0] word;
   logic err_lamp;
   logic rdy_lamp;
   modport ctl (output tick, output mode, output word, input err_lamp, input rdy_lamp);
   modport lamp (input tick, input mode, input word, output err_lamp, output rdy_lamp);
endinterface : odls_lamp_if
`default_nettype wire

// [odls_lamp_seq.sv]
`include "odls_params.svh"
`default_nettype none
module odls_lamp_seq (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   odls_lamp_if.lamp lif
);
   import odls_pkg::*;
   typedef enum logic [2:0] {L_IDLE, L_LEAD, L_ON, L_OFF, L_PAUSE} odls_lstate_t;
   odls_lstate_t state_reg;
   logic [4:0] tmr_reg;
   logic [3:0] cnt_reg;
   logic grp_reg;
   logic [15:0] sh_reg;
   logic expire;
   logic [3:0] elems0;
   logic [3:0] elems1;
   logic is_addr;

   assign is_addr = (lif.mode == LM_ADDR);
   assign expire = lif.tick && (tmr_reg == 5'(`ODLS_PULSE_TICKS));
   // Address shows eight bits per group; an error code shows one pulse per unit of its digit
   assign elems0 = is_addr ? `ODLS_ADDR_BITS : lif.word[7:4];
   assign elems1 = is_addr ? `ODLS_ADDR_BITS : lif.word[3:0];

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= L_IDLE;
         tmr_reg <= 5'h00;
         cnt_reg <= 4'h0;
         grp_reg <= 1'b0;
         sh_reg <= 16'h0000;
         lif.err_lamp <= 1'b0;
         lif.rdy_lamp <= 1'b0;
      end
      else if (lif.mode == LM_OFF)
      begin
         state_reg <= L_IDLE;
         lif.err_lamp <= 1'b0;
         lif.rdy_lamp <= 1'b0;
      end
      else
      begin
         if (lif.tick && tmr_reg != 5'h00)
            tmr_reg <= tmr_reg - 5'h01;
         unique case (state_reg)
            // Start on a tick so that the lead lasts whole ticks
            L_IDLE:
               if (lif.tick)
               begin
                  state_reg <= L_LEAD;
                  tmr_reg <= 5'(`ODLS_LEAD_TICKS);
                  grp_reg <= 1'b0;
                  sh_reg <= lif.word;
                  lif.err_lamp <= 1'b1;
                  lif.rdy_lamp <= 1'b0;
               end
            L_LEAD:
               if (expire)
               begin
                  state_reg <= L_OFF;
                  tmr_reg <= 5'(`ODLS_PULSE_TICKS);
                  cnt_reg <= elems0;
                  lif.err_lamp <= 1'b0;
               end
            L_ON:
               if (expire)
               begin
                  state_reg <= L_OFF;
                  tmr_reg <= 5'(`ODLS_PULSE_TICKS);
                  cnt_reg <= cnt_reg - 4'h1;
                  sh_reg <= {sh_reg[14:0], 1'b0};
                  lif.err_lamp <= 1'b0;
                  lif.rdy_lamp <= 1'b0;
               end
            L_OFF:
               if (expire)
               begin
                  if (cnt_reg == 4'h0)
                  begin
                     state_reg <= L_PAUSE;
                     tmr_reg <= 5'(`ODLS_PAUSE_TICKS);
                  end
                  else
                  begin
                     state_reg <= L_ON;
                     tmr_reg <= 5'(`ODLS_PULSE_TICKS);
                     lif.err_lamp <= 1'b1;
                     lif.rdy_lamp <= is_addr & sh_reg[15];
                  end
               end
            L_PAUSE:
               if (expire)
               begin
                  if (!grp_reg)
                  begin
                     state_reg <= L_OFF;
                     tmr_reg <= 5'(`ODLS_PULSE_TICKS);
                     grp_reg <= 1'b1;
                     cnt_reg <= elems1;
                  end
                  else
                  begin
                     state_reg <= L_LEAD;
                     tmr_reg <= 5'(`ODLS_LEAD_TICKS);
                     grp_reg <= 1'b0;
                     sh_reg <= lif.word;
                     lif.err_lamp <= 1'b1;
                  end
               end
         endcase
      end
   end
endmodule : odls_lamp_seq
`default_nettype wire

// [odls_props.sv]
`default_nettype none
module odls_chk #(
   parameter int unsigned TICK_CYC = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic op_valid_o,
   input wire odls_pkg::odls_op_t op_code_o,
   input wire logic [15:0] op_arg_o,
   input wire logic op_done_i,
   input wire logic op_err_i,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [23:0] mem_addr_o,
   input wire logic [7:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic error_lamp_o,
   input wire logic ready_lamp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import odls_pkg::*;
   int unsigned on_cnt;
   int unsigned cyc;
   // Length of the current error lamp on-run
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         on_cnt <= 0;
      else
         on_cnt <= error_lamp_o ? on_cnt + 1 : 0;
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cyc <= 0;
      else if (cyc < 20 * TICK_CYC)
         cyc <= cyc + 1;
   end
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_op_held: assert property (op_valid_o && !op_done_i |=> op_valid_o
      && $stable(op_code_o) && $stable(op_arg_o)) else $error("op changed before done");
   a_op_release: assert property (op_valid_o && op_done_i |=> !op_valid_o)
      else $error("op held after done");
   a_op_halt: assert property (op_valid_o && op_done_i && op_err_i |=>
      !op_valid_o [*8]) else $error("op issued after error");
   a_ready_dark: assert property (op_valid_o && op_done_i && op_err_i |->
      ##[1:6] !ready_lamp_o ##1 !ready_lamp_o [*8]) else $error("ready lamp on after error");
   a_mem_held: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
      $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
      else $error("memory request changed before ack");
   a_mem_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
      else $error("memory request held after ack");
   a_mem_range: assert property (mem_req_o |-> mem_addr_o <= 24'h000FFF)
      else $error("memory address out of range");
   a_mem_warmup: assert property ($rose(mem_req_o) |-> cyc >= 12 * TICK_CYC)
      else $error("memory run before ready time");
   a_lamp_tick: assert property ($fell(error_lamp_o) |-> on_cnt % TICK_CYC == 0)
      else $error("lamp on-time not whole ticks");
   a_lamp_len: assert property ($fell(error_lamp_o) |->
      on_cnt == TICK_CYC || on_cnt == 12 * TICK_CYC) else $error("lamp on-time wrong");
endmodule : odls_chk
bind odls_top odls_chk #(.TICK_CYC(TICK_CYC)) odls_chk_inst (.sys_clk_i, .rst_n_i,
   .op_valid_o, .op_code_o, .op_arg_o, .op_done_i, .op_err_i, .mem_req_o, .mem_we_o,
   .mem_addr_o, .mem_wdata_o, .mem_ack_i, .error_lamp_o, .ready_lamp_o);
`default_nettype wire

// [odls_far.sv]
`default_nettype none
module odls_far (
   input wire logic sys_clk_i,
   input wire logic op_valid_i,
   input wire odls_pkg::odls_op_t op_code_i,
   input wire logic [15:0] op_arg_i,
   output logic op_done_o = 1'b0,
   output logic op_err_o = 1'b0,
   output logic [7:0] op_err_code_o = 8'h00,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [23:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic mem_ack_o = 1'b0,
   output logic [7:0] mem_rdata_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   import odls_pkg::*;
   int fail_at = -1;
   logic [7:0] fail_code = 8'h00;
   logic mem_bad = 1'b0;
   logic [19:0] log_q[$];
   logic [7:0] mem[4096];
   int n = 0;
   int w = 0;
   int mw = 0;
   int rd_n = 0;
   // Drives answer after 0, 1 or 2 cycles in turn; code lines churn when not valid
   always @(negedge sys_clk_i)
   begin
      op_done_o <= 1'b0;
      op_err_o <= 1'b0;
      op_err_code_o <= ~op_err_code_o;
      if (op_valid_i && !op_done_o)
      begin
         if (w == n % 3)
         begin
            op_done_o <= 1'b1;
            op_err_o <= (n == fail_at);
            op_err_code_o <= fail_code;
            log_q.push_back({op_code_i, op_arg_i});
            n++;
            w = 0;
         end
         else
            w++;
      end
   end
   // Memory fills the whole low range, priority always granted, bus clock always present
   always @(negedge sys_clk_i)
   begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o)
      begin
         if (mw == int'(mem_addr_i[0]))
         begin
            mem_ack_o <= 1'b1;
            if (mem_we_i)
               mem[mem_addr_i[11:0]] = mem_wdata_i;
            else
            begin
               mem_rdata_o <= mem[mem_addr_i[11:0]] ^ {7'h00, mem_bad};
               rd_n++;
            end
            mw = 0;
         end
         else
            mw++;
      end
   end
endmodule : odls_far
`default_nettype wire

// [odls_tb_top.sv]
`default_nettype none
module odls_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import odls_pkg::*;
   localparam int T = 4;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [5:0] sel = 6'h00;
   logic [15:0] wake = 16'h0000;
   logic [4:0] drv = 5'h00;
   logic op_valid_o, op_done_i, op_err_i, mem_req_o, mem_we_o, mem_ack_i;
   logic error_lamp_o, ready_lamp_o;
   odls_op_t op_code_o;
   logic [2:0] op_unit_o;
   logic [15:0] op_arg_o;
   logic [7:0] op_err_code_i, mem_wdata_o, mem_rdata_i;
   logic [23:0] mem_addr_o;
   int error_cnt = 0;
   int checked = 0;
   logic [19:0] eq[$];
   always #20 sys_clk_i = ~sys_clk_i;
   odls_top #(.TICK_CYC(T)) odls_top_inst (.sys_clk_i, .rst_n_i,
      .test_select_jumpers_i(sel), .wakeup_jumpers_i(wake), .drive_present_i(drv),
      .op_valid_o, .op_code_o, .op_unit_o, .op_arg_o, .op_done_i, .op_err_i, .op_err_code_i,
      .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i,
      .error_lamp_o, .ready_lamp_o);
   odls_far odls_far_inst (.sys_clk_i, .op_valid_i(op_valid_o), .op_code_i(op_code_o),
      .op_arg_i(op_arg_o), .op_done_o(op_done_i), .op_err_o(op_err_i),
      .op_err_code_o(op_err_code_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
      .mem_rdata_o(mem_rdata_i));
   task automatic results;
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic start(input logic [5:0] s, input logic [4:0] d, input logic [15:0] wv);
      @(negedge sys_clk_i);
      rst_n_i = 1'b0;
      sel = s;
      drv = d;
      wake = wv;
      repeat (6) @(negedge sys_clk_i);
      eq.delete();
      odls_far_inst.log_q.delete();
      odls_far_inst.n = 0;
      odls_far_inst.w = 0;
      odls_far_inst.mw = 0;
      odls_far_inst.fail_at = -1;
      rst_n_i = 1'b1;
   endtask : start
   task automatic wt(input logic v);
      int k;
      k = 0;
      while (error_lamp_o !== v && k < 40000)
      begin
         k++;
         @(negedge sys_clk_i);
      end
   endtask : wt
   task automatic len(input logic v, output int n);
      n = 0;
      while (error_lamp_o === v && n < 2000)
      begin
         n++;
         @(negedge sys_clk_i);
      end
   endtask : len
   task automatic ex(input odls_op_t c, input logic [15:0] a);
      eq.push_back({c, a});
   endtask : ex
   // Arguments of FFFF are not compared
   task automatic chk_ops;
      int i;
      i = 0;
      while (odls_far_inst.log_q.size() < eq.size() && i < 5000)
      begin
         i++;
         @(negedge sys_clk_i);
      end
      foreach (eq[k])
      begin
         cmp(odls_far_inst.log_q[k][19:16], eq[k][19:16]);
         if (eq[k][15:0] != 16'hFFFF)
            cmp(odls_far_inst.log_q[k][15:0], eq[k][15:0]);
      end
      repeat (8) @(negedge sys_clk_i);
      cmp(ready_lamp_o, 1'b1);
   endtask : chk_ops
   task automatic blink(input logic [7:0] code);
      int n, m, d;
      logic [7:0] got;
      got = 8'h00;
      wt(1'b1);
      cmp(ready_lamp_o, 1'b0);
      len(1'b1, n);
      cmp(n, 12 * T);
      len(1'b0, n);
      for (d = 1; d >= 0; d--)
      begin
         do
         begin
            len(1'b1, m);
            got[d * 4 +: 4] = got[d * 4 +: 4] + 4'h1;
            len(1'b0, n);
         end
         while (n <= T);
         cmp(n >= 8 * T, 1'b1);
      end
      cmp(got, code);
      len(1'b1, n);
      cmp(n, 12 * T);
   endtask : blink
   task automatic s_floppy;
      int i;
      start(6'h18, 5'h02, 16'h0000);
      odls_far_inst.fail_at = 50;
      while (op_valid_o !== 1'b1)
         @(negedge sys_clk_i);
      cmp(op_unit_o, 3'h1);
      odls_far_inst.fail_code = 8'h34;
      ex(OP_SEEK_HOME, 16'hFFFF);
      ex(OP_STEP_OUT, 16'h0023);
      ex(OP_SEEK_ZERO, 16'hFFFF);
      ex(OP_READ_ID, 16'hFFFF);
      for (i = 0; i < 32; i++)
         ex(i < 16 ? OP_WRITE_SECT : OP_VERIFY_SECT, 16'(i % 16));
      chk_ops();
      blink(8'h34);
   endtask : s_floppy
   task automatic s_system;
      int i;
      start(6'h14, 5'h14, 16'h0000);
      ex(OP_ENV_TEST, 16'hFFFF);
      ex(OP_SEQ_TEST, 16'hFFFF);
      ex(OP_SEEK_HOME, 16'hFFFF);
      ex(OP_STEP_OUT, 16'h0080);
      ex(OP_SEEK_ZERO, 16'hFFFF);
      ex(OP_READ_ID, 16'hFFFF);
      for (i = 0; i < 12; i++)
         ex(OP_READ_ECC, 16'(i));
      ex(OP_RETENSION, 16'hFFFF);
      for (i = 0; i < 4; i++)
         ex(i < 2 ? OP_TAPE_WRITE : OP_TAPE_VERIFY, 16'(i % 2));
      chk_ops();
      start(6'h14, 5'h00, 16'h0000);
      blink(8'h47);
   endtask : s_system
   task automatic s_addr;
      int n, i;
      start(6'h1A, 5'h00, 16'h0F70);
      wt(1'b1);
      len(1'b1, n);
      cmp(n, 12 * T);
      len(1'b0, n);
      for (i = 15; i >= 0; i--)
      begin
         repeat (2) @(negedge sys_clk_i);
         cmp(ready_lamp_o, wake[i]);
         len(1'b1, n);
         len(1'b0, n);
         if (i == 8 || i == 0)
            cmp(n >= 8 * T, 1'b1);
      end
      len(1'b1, n);
      cmp(n, 12 * T);
   endtask : s_addr
   task automatic s_mem;
      int i;
      start(6'h13, 5'h00, 16'h0000);
      odls_far_inst.rd_n = 0;
      odls_far_inst.mem_bad = 1'b0;
      i = 0;
      while (ready_lamp_o !== 1'b1 && i < 60000)
      begin
         i++;
         @(negedge sys_clk_i);
      end
      cmp(odls_far_inst.rd_n, 4096);
      odls_far_inst.mem_bad = 1'b1;
      blink(8'hE1);
   endtask : s_mem
   // Test order follows the prerequisite chain of the operator
   initial
   begin
      s_system();
      s_floppy();
      s_addr();
      s_mem();
      results();
   end
   initial
   begin
      #(90000 * 40);
      error_cnt++;
      results();
   end
endmodule : odls_tb_top
`default_nettype wire
